// ### verilog/stl_link.sv
// sync-tag parallel io link: controller words, 32 io lines, tag events
//
// Overview of operation
// RL1 - all output lines update in one write
// RL2 - all input lines captured in one sample
// RL3 - commands carry ones in bits 24..22
// RL4 - lower data word: bit24 and bit16 clear
// RL5 - upper data word: bit24 clear, bit16 set
// RL6 - reply command: bit24 set, bits 15..8 zero
// RL7 - tag packet: bit24, flags 13 and 12 only
// RL8 - every tag event sends a tag packet
// RL9 - finish data pair before tag packet
// RL10 - controller avoids reads when syncing tightly
// RL11 - only one module generates sync events
// RL12 - start and second tags have own modes
// RL13 - external mode fires on rising edge
// RL14 - external second tag uses second line
// RL15 - internal start: command fires, line input
// RL16 - start output mode: 500 ns high pulse
// RL17 - internal second tag at 1 Hz
// RL18 - second output mode: 470 ms high
// RL19 - strapped ports power up driving low
// RL20 - readable serial number
// RL21 - accept commands, reply, access ports
// RL22 - four eight-bit ports, 32 lines
// RL23 - per-port direction set by software
// RL24 - strapped port stays output always
// RL25 - tag packet flags only fired tags
`timescale 1ns/1ps
`default_nettype none
module stl_link
  import stl_pkg::*;
#(
  parameter int          SEC_PERIOD = SEC_PERIOD_CYC,
  parameter int          SEC_HIGH   = SEC_HIGH_CYC,
  parameter logic [31:0] SERIAL     = SERIAL_DEF,   // arbitrary value
  parameter int          DEPTH      = FIFO_DEPTH
)
(
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                rx_valid,
  input  wire logic [WORD_W-1:0]   rx_word,
  output logic                     rx_ready,
  output logic                     tx_valid,
  output logic [WORD_W-1:0]        tx_word,
  input  wire logic                tx_ready,
  input  wire logic [LINES-1:0]    io_in,
  output logic [LINES-1:0]         io_out,
  output logic [PORTS-1:0]         io_oe_n,
  input  wire logic [PORTS-1:0]    port_dir_out,
  input  wire logic [PORTS-1:0]    power_on_low_straps,
  input  wire stl_tag_mode_t       start_mode,
  input  wire stl_tag_mode_t       second_mode,
  input  wire logic                start_tag_in,
  output logic                     start_tag_out,
  output logic                     start_tag_oe_n,
  input  wire logic                second_tag_in,
  output logic                     second_tag_out,
  output logic                     second_tag_oe_n
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [LINES-1:0] io_s1_r, io_s2_r;
  logic [PORTS-1:0] strap_s1_r, strap_s2_r, strap_r;
  logic             strap_done_r;
  logic [1:0]       strap_age_r;
  logic [2:0]       st_sync_r, sec_sync_r;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      io_s1_r      <= '0;
      io_s2_r      <= '0;
      strap_s1_r   <= '0;
      strap_s2_r   <= '0;
      strap_r      <= '0;
      strap_done_r <= 1'b0;
      strap_age_r  <= 2'h0;
      st_sync_r    <= '0;
      sec_sync_r   <= '0;
    end
    else
    begin
      io_s1_r    <= io_in;
      io_s2_r    <= io_s1_r;
      strap_s1_r <= power_on_low_straps;
      strap_s2_r <= strap_s1_r;
      // straps are caught once the synchroniser holds a real sample, then frozen
      if (!strap_done_r)
      begin
        strap_age_r <= strap_age_r + 2'h1;
        if (strap_age_r == 2'h2)
        begin
          strap_r      <= strap_s2_r;                   // RL19
          strap_done_r <= 1'b1;
        end
      end
      st_sync_r  <= {st_sync_r[1:0], start_tag_in};
      sec_sync_r <= {sec_sync_r[1:0], second_tag_in};
    end
  end

  // ----------------------------------------------------------------
  // command and data decode
  // ----------------------------------------------------------------
  logic                rx_ready_r, rx_ready_nxt;
  logic                take;
  logic                is_cmd, is_data;
  logic [1:0]          opcode;
  logic [15:0]         stage_lo_r, stage_lo_nxt;
  logic [LINES-1:0]    out_val_r, out_val_nxt;
  logic [LINES-1:0]    snap_r, snap_nxt;
  logic                rd_pend_r, rd_pend_nxt;
  logic                rsp_pend_r, rsp_pend_nxt;
  logic [WORD_W-1:0]   rsp_word_r, rsp_word_nxt;
  logic                sw_start;
  logic                acc_rd_lo, acc_rd_hi, acc_rsp;

  assign take    = rx_valid & rx_ready_r;
  assign is_cmd  = rx_word[BIT_CMD -: 3] == CMD_MARK;  // RL3
  assign is_data = ~rx_word[BIT_CMD];                   // RL4 RL5
  assign opcode  = rx_word[21:20];
  assign sw_start = take & is_cmd & (opcode == OP_START);

  always_comb
  begin
    stage_lo_nxt = stage_lo_r;
    out_val_nxt  = out_val_r;
    snap_nxt     = snap_r;
    rd_pend_nxt  = rd_pend_r & ~acc_rd_hi;
    rsp_pend_nxt = rsp_pend_r & ~acc_rsp;
    rsp_word_nxt = rsp_word_r;
    if (take & is_data & ~rx_word[BIT_HALF])
      stage_lo_nxt = rx_word[15:0];                     // RL4
    // both halves land in one register load
    if (take & is_data & rx_word[BIT_HALF])
      out_val_nxt = {rx_word[15:0], stage_lo_r};        // RL1 RL5 RL21
    if (take & is_cmd & (opcode == OP_READ))
    begin
      snap_nxt    = io_s2_r;                            // RL2
      rd_pend_nxt = 1'b1;
    end
    if (take & is_cmd & (opcode == OP_SERIAL))
    begin
      rsp_pend_nxt = 1'b1;
      rsp_word_nxt = {1'b1, rx_word[23:16], 8'h00,
                      SERIAL[8*rx_word[1:0] +: 8]};     // RL6 RL20
    end
    // hold off new words while a reply is still owed
    rx_ready_nxt = ~rd_pend_nxt & ~rsp_pend_nxt;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_ready_r <= 1'b0;
      stage_lo_r <= '0;
      out_val_r  <= OUT_RST;                            // RL19
      snap_r     <= '0;
      rd_pend_r  <= 1'b0;
      rsp_pend_r <= 1'b0;
      rsp_word_r <= '0;
    end
    else
    begin
      rx_ready_r <= rx_ready_nxt;
      stage_lo_r <= stage_lo_nxt;
      out_val_r  <= out_val_nxt;
      snap_r     <= snap_nxt;
      rd_pend_r  <= rd_pend_nxt;
      rsp_pend_r <= rsp_pend_nxt;
      rsp_word_r <= rsp_word_nxt;
    end
  end

  // ----------------------------------------------------------------
  // port drivers
  // ----------------------------------------------------------------
  logic [PORTS-1:0] oe_n_r, oe_n_nxt;

  always_comb
  begin
    // a strapped port never returns to input
    oe_n_nxt = ~(port_dir_out | strap_r);               // RL22 RL23 RL24
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      oe_n_r <= '1;
    else
      oe_n_r <= oe_n_nxt;
  end

  assign io_out  = out_val_r;
  assign io_oe_n = oe_n_r;

  // ----------------------------------------------------------------
  // tag event sources
  // ----------------------------------------------------------------
  logic [4:0]  st_cnt_r, st_cnt_nxt;
  logic        st_out_r, st_out_nxt;
  logic        st_oe_n_r, st_oe_n_nxt;
  logic [25:0] sec_cnt_r, sec_cnt_nxt;
  logic        sec_out_r, sec_out_nxt;
  logic        sec_oe_n_r, sec_oe_n_nxt;
  logic        st_ev, sec_ev;

  always_comb
  begin
    st_cnt_nxt = (st_cnt_r != '0) ? st_cnt_r - 5'h01 : st_cnt_r;
    unique case (start_mode)                            // RL12
      TAG_EXT:
        st_ev = st_sync_r[1] & ~st_sync_r[2];           // RL13
      TAG_INT:
        st_ev = sw_start;                               // RL15
      TAG_INT_OUT:
      begin
        st_ev = sw_start;
        if (sw_start)
          st_cnt_nxt = 5'(START_PULSE_CYC);             // RL16
      end
      default:
        st_ev = 1'b0;
    endcase
    st_out_nxt  = (st_cnt_nxt != '0);
    st_oe_n_nxt = (start_mode != TAG_INT_OUT);          // RL15
  end

  always_comb
  begin
    // divider held at zero in external mode; the tag fires as the count wraps
    if (second_mode == TAG_EXT || sec_cnt_r == 26'(SEC_PERIOD - 1))
      sec_cnt_nxt = '0;
    else
      sec_cnt_nxt = sec_cnt_r + 26'h1;
    unique case (second_mode)
      TAG_EXT:
        sec_ev = sec_sync_r[1] & ~sec_sync_r[2];        // RL13 RL14
      TAG_INT, TAG_INT_OUT:
        sec_ev = (sec_cnt_r == 26'(SEC_PERIOD - 1));    // RL17
      default:
        sec_ev = 1'b0;
    endcase
    // the high phase only starts at an event, so a mode switch gives no runt pulse
    sec_out_nxt  = (second_mode == TAG_INT_OUT) &&
                   (sec_ev || (sec_out_r && (sec_cnt_nxt < 26'(SEC_HIGH))));  // RL18
    sec_oe_n_nxt = (second_mode != TAG_INT_OUT);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_cnt_r   <= '0;
      st_out_r   <= 1'b0;
      st_oe_n_r  <= 1'b1;
      sec_cnt_r  <= '0;
      sec_out_r  <= 1'b0;
      sec_oe_n_r <= 1'b1;
    end
    else
    begin
      st_cnt_r   <= st_cnt_nxt;
      st_out_r   <= st_out_nxt;
      st_oe_n_r  <= st_oe_n_nxt;
      sec_cnt_r  <= sec_cnt_nxt;
      sec_out_r  <= sec_out_nxt;
      sec_oe_n_r <= sec_oe_n_nxt;
    end
  end

  assign start_tag_out   = st_out_r;
  assign start_tag_oe_n  = st_oe_n_r;
  assign second_tag_out  = sec_out_r;
  assign second_tag_oe_n = sec_oe_n_r;

  // ----------------------------------------------------------------
  // transmit arbiter
  // ----------------------------------------------------------------
  stl_stream_if #(.W(WORD_W)) push_if ();
  stl_stream_if #(.W(WORD_W)) pop_if ();
  stl_tx_state_t       tx_r, tx_nxt;
  logic                st_pend_r, st_pend_nxt;
  logic                sec_pend_r, sec_pend_nxt;
  logic                acc_tag, push_ok;
  logic                txv_r, txv_nxt;
  logic [WORD_W-1:0]   txw_r, txw_nxt;

  assign push_ok = push_if.valid & push_if.ready;

  always_comb
  begin
    push_if.valid = 1'b0;
    push_if.data  = '0;
    tx_nxt        = tx_r;
    acc_tag       = 1'b0;
    acc_rsp       = 1'b0;
    acc_rd_lo     = 1'b0;
    acc_rd_hi     = 1'b0;
    unique case (tx_r)
      TX_IDLE:
      begin
        if (st_pend_r | sec_pend_r)
        begin
          push_if.valid = 1'b1;
          push_if.data  = '0;
          push_if.data[BIT_CMD]    = 1'b1;              // RL7
          push_if.data[BIT_SECTAG] = sec_pend_r;        // RL25
          push_if.data[BIT_STTAG]  = st_pend_r;
          acc_tag = push_ok;
        end
        else if (rsp_pend_r)
        begin
          push_if.valid = 1'b1;
          push_if.data  = rsp_word_r;
          acc_rsp = push_ok;
        end
        else if (rd_pend_r)
        begin
          push_if.valid = 1'b1;
          push_if.data  = {1'b0, 7'h00, 1'b0, snap_r[15:0]};   // RL4
          acc_rd_lo = push_ok;
          if (push_ok)
            tx_nxt = TX_UPPER;
        end
      end
      TX_UPPER:
      begin
        // the pair is never split by a tag packet
        push_if.valid = 1'b1;                           // RL9
        push_if.data  = {1'b0, 7'h00, 1'b1, snap_r[31:16]};    // RL5
        acc_rd_hi = push_ok;
        if (push_ok)
          tx_nxt = TX_IDLE;
      end
    endcase
    // a new event in the clearing cycle stays pending
    st_pend_nxt  = st_ev | (st_pend_r & ~acc_tag);      // RL8
    sec_pend_nxt = sec_ev | (sec_pend_r & ~acc_tag);
    pop_if.ready = ~txv_r | tx_ready;
    txv_nxt = txv_r;
    txw_nxt = txw_r;
    if (pop_if.ready)
    begin
      txv_nxt = pop_if.valid;
      txw_nxt = pop_if.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_r       <= TX_IDLE;
      st_pend_r  <= 1'b0;
      sec_pend_r <= 1'b0;
      txv_r      <= 1'b0;
      txw_r      <= '0;
    end
    else
    begin
      tx_r       <= tx_nxt;
      st_pend_r  <= st_pend_nxt;
      sec_pend_r <= sec_pend_nxt;
      txv_r      <= txv_nxt;
      txw_r      <= txw_nxt;
    end
  end

  stl_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_fifo
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr      (push_if),
    .rd      (pop_if)
  );

  assign rx_ready = rx_ready_r;
  assign tx_valid = txv_r;
  assign tx_word  = txw_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_out_update;
    (take & is_data & rx_word[BIT_HALF]) |=> (io_out == {$past(rx_word[15:0]), $past(stage_lo_r)});
  endproperty
  a_out_update: assert property (p_out_update) else $error("outputs not loaded together"); // RL1

  property p_tag_word;
    (push_ok & (tx_r == TX_IDLE) & (st_pend_r | sec_pend_r)) |->
      ((push_if.data & ~25'h0_3000) == 25'h100_0000) && (push_if.data[13:12] != 2'h0);
  endproperty
  a_tag_word: assert property (p_tag_word) else $error("bad tag packet layout"); // RL7

  property p_reply_zero;
    (push_ok & acc_rsp) |-> (push_if.data[BIT_CMD] && push_if.data[15:8] == 8'h00);
  endproperty
  a_reply_zero: assert property (p_reply_zero) else $error("reply word layout wrong"); // RL6

  property p_pair_order;
    acc_rd_lo |=> (push_if.valid && push_if.data[BIT_HALF] && !push_if.data[BIT_CMD]);
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("upper half not next"); // RL9

  property p_lower_half;
    acc_rd_lo |-> (push_if.data[BIT_CMD:BIT_HALF] == 9'h000);
  endproperty
  a_lower_half: assert property (p_lower_half) else $error("lower half flags wrong"); // RL4

  property p_event_pends;
    st_ev |=> st_pend_r;
  endproperty
  a_event_pends: assert property (p_event_pends) else $error("start event lost"); // RL8

  property p_start_pulse;
    $rose(st_out_r) |-> (st_out_r[*8] ##[1:16] !st_out_r);
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse width wrong"); // RL16

  property p_strap_out;
    (strap_done_r && $past(strap_done_r)) |-> ((io_oe_n & strap_r) == '0);
  endproperty
  a_strap_out: assert property (p_strap_out) else $error("strapped port not driving"); // RL24

  property p_int_start_in;
    (start_mode == TAG_INT) |=> start_tag_oe_n;
  endproperty
  a_int_start_in: assert property (p_int_start_in) else $error("start line driven in internal mode"); // RL15
endmodule
`default_nettype wire

// ### verilog/stl_pkg.sv
// constants and types shared by the sync-tag parallel io link
package stl_pkg;

  // ----------------------------------------------------------------
  // word layout on the controller link
  // ----------------------------------------------------------------
  localparam int WORD_W     = 25;
  localparam int BIT_CMD    = 24;
  localparam int BIT_HALF   = 16;
  localparam int BIT_SECTAG = 13;
  localparam int BIT_STTAG  = 12;
  localparam logic [2:0] CMD_MARK = 3'h7;
  localparam logic [1:0] OP_READ   = 2'h0;
  localparam logic [1:0] OP_START  = 2'h1;
  localparam logic [1:0] OP_SERIAL = 2'h2;

  // ----------------------------------------------------------------
  // ports and reset values
  // ----------------------------------------------------------------
  localparam int PORTS   = 4;
  localparam int PORT_W  = 8;
  localparam int LINES   = PORTS * PORT_W;
  localparam logic [31:0] OUT_RST = 32'h0000_0000;
  localparam logic [31:0] SERIAL_DEF = 32'h0000_1234;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int START_PULSE_NS  = 500;
  localparam int START_PULSE_CYC = (START_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SEC_FREQ_HZ     = 1;
  localparam int SEC_PERIOD_CYC  = CLK_HZ / SEC_FREQ_HZ;
  localparam int SEC_HIGH_MS     = 470;
  localparam int SEC_HIGH_CYC    = SEC_HIGH_MS * (CLK_HZ / 1000);
  localparam int FIFO_DEPTH      = 16;

  typedef enum logic [1:0]
  {
    TAG_EXT     = 2'b00,
    TAG_INT     = 2'b01,
    TAG_INT_OUT = 2'b10
  } stl_tag_mode_t;

  typedef enum logic
  {
    TX_IDLE  = 1'b0,
    TX_UPPER = 1'b1
  } stl_tx_state_t;

endpackage

// ### verilog/stl_stream_if.sv
// valid/ready word stream between the link core and its fifo
`timescale 1ns/1ps
`default_nettype none
interface stl_stream_if #(parameter int W = 25);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### verilog/stl_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stl_fifo
  import stl_pkg::*;
#(
  parameter int W     = 25,
  parameter int DEPTH = 16
)
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  stl_stream_if.snk wr,
  stl_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          do_wr, do_rd;

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_r != '0);
  assign rd.data  = mem_r[rp_r];
  assign do_wr    = wr.valid & wr.ready;
  assign do_rd    = rd.valid & rd.ready;

  always_comb
  begin
    wp_nxt  = do_wr ? wp_r + 1'b1 : wp_r;
    rp_nxt  = do_rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage holds no reset; only written slots are ever read
  always_ff @(posedge sys_clk)
  begin
    if (do_wr)
      mem_r[wp_r] <= wr.data;
  end
endmodule
`default_nettype wire

// ### test/stl_ctl_model.sv
// controller-side model: word source and word sink on the link streams
`timescale 1ns/1ps
`default_nettype none
module stl_ctl_model
  import stl_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  output logic                   rx_valid,
  output logic [WORD_W-1:0]      rx_word,
  input  wire logic              rx_ready,
  input  wire logic              tx_valid,
  input  wire logic [WORD_W-1:0] tx_word,
  output logic                   tx_ready,
  input  wire logic              tx_hold
);
  logic [WORD_W-1:0] rxq[$];
  logic [WORD_W-1:0] txq[$];

  // ----------------------------------------------------------------
  // word source holds each word until taken; idle bus toggles so a
  // stale word can never pass for a fresh one
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_valid <= 1'b0;
      rx_word  <= '0;
      tx_ready <= 1'b0;
    end
    else
    begin
      if (rx_valid && rx_ready)
        void'(rxq.pop_front());
      if (tx_valid && tx_ready)
        txq.push_back(tx_word);
      tx_ready <= !tx_hold;
      if (rxq.size() > 0)
      begin
        rx_valid <= 1'b1;
        rx_word  <= rxq[0];
      end
      else
      begin
        rx_valid <= 1'b0;
        rx_word  <= ~rx_word;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/stl_link_tb_top.sv
// self-checking bench for the sync-tag parallel io link
`timescale 1ns/1ps
`default_nettype none
module stl_link_tb_top;
  import stl_pkg::*;
  localparam int          SPER  = 1000;
  localparam int          SHIGH = 470;
  localparam logic [31:0] SER   = 32'h5a3c_96e1; // arbitrary value
  localparam int          LIMIT = 20000;
  logic              sys_clk = 1'b0;
  logic              rstn    = 1'b0;
  logic              rx_valid, rx_ready, tx_valid, tx_ready, tx_hold, stall;
  logic [WORD_W-1:0] rx_word, tx_word;
  logic [LINES-1:0]  io_in, io_out, pins;
  logic [PORTS-1:0]  io_oe_n, dir_out, straps;
  stl_tag_mode_t     st_mode, sc_mode;
  logic              st_out, st_oe_n, sc_out, sc_oe_n, st_ext, sc_ext, st_in, sc_in;
  logic [31:0]       out_m;
  logic [WORD_W-1:0] expq[$];
  int                seed = 32'ha3116a06;
  int                err_total = 0;
  int                n_checks = 0;
  int                cyc = 0;
  int                n;
  int                i;

  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // pin resolution: a driving port wins, otherwise the outside level
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PORTS; p++)
  begin : g_pin
    assign io_in[p*PORT_W +: PORT_W] = io_oe_n[p] ? pins[p*PORT_W +: PORT_W] : io_out[p*PORT_W +: PORT_W];
  end
  assign st_in = st_oe_n ? st_ext : st_out;
  assign sc_in = sc_oe_n ? sc_ext : sc_out;

  // only this one module generates sync events
  stl_link #(.SEC_PERIOD(SPER), .SEC_HIGH(SHIGH), .SERIAL(SER), .DEPTH(FIFO_DEPTH)) i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n), .port_dir_out(dir_out), .power_on_low_straps(straps), .start_mode(st_mode),
    .second_mode(sc_mode), .start_tag_in(st_in), .start_tag_out(st_out), .start_tag_oe_n(st_oe_n),
    .second_tag_in(sc_in), .second_tag_out(sc_out), .second_tag_oe_n(sc_oe_n));

  stl_ctl_model i_ctl (
    .sys_clk(sys_clk), .rstn(rstn), .rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready), .tx_hold(tx_hold));

  // random stalls on the sink side; stall forces a full back-pressure
  always @(posedge sys_clk)
    tx_hold <= stall | (($random(seed) & 3) == 0);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_io(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [WORD_W-1:0] w);
    @(negedge sys_clk);
    i_ctl.rxq.push_back(w);
  endtask

  // port read: driving ports echo their own levels, the rest the pins
  task automatic rd();
    logic [31:0] e;
    for (int p = 0; p < PORTS; p++)
      e[p*8 +: 8] = (dir_out[p] | straps[p]) ? out_m[p*8 +: 8] : pins[p*8 +: 8];
    send(25'h1c00000);
    expq.push_back({9'h000, e[15:0]});
    expq.push_back({8'h00, 1'b1, e[31:16]});
  endtask

  // wait for the expected count, allow stragglers to show, compare in order
  task automatic drain();
    int k;
    k = 0;
    while (i_ctl.txq.size() < expq.size() && k < 3000)
    begin
      @(posedge sys_clk);
      k++;
    end
    repeat (12) @(posedge sys_clk);
    chk_io(i_ctl.txq.size(), expq.size());
    while (expq.size() > 0 && i_ctl.txq.size() > 0)
      chk_word(i_ctl.txq.pop_front(), expq.pop_front());
    expq.delete();
    i_ctl.txq.delete();
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      $display("unexpected hang at %0t: cycles %h limit %h", $time, cyc, LIMIT);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pins    = 32'h0000_0000;
    dir_out = 4'h0;
    straps  = 4'($random(seed));
    st_mode = stl_tag_mode_t'(2'h3);
    sc_mode = stl_tag_mode_t'(2'h3);
    st_ext  = 1'b0;
    sc_ext  = 1'b0;
    stall   = 1'b0;
    tx_hold = 1'b1;
    out_m   = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk_io({28'h0, io_oe_n}, {28'h0, ~straps});
    chk_io(io_out, 32'h0000_0000);
    $display("test reset done");
    dir_out <= 4'hf;
    out_m = $random(seed);
    send({9'h000, out_m[15:0]});
    repeat (8) @(posedge sys_clk);
    chk_io(io_out, 32'h0000_0000);
    send({8'h00, 1'b1, out_m[31:16]});
    repeat (8) @(posedge sys_clk);
    chk_io(io_out, out_m);
    chk_io({28'h0, io_oe_n}, 32'h0000_0000);
    $display("test write done");
    dir_out <= 4'($random(seed));
    pins <= $random(seed);
    repeat (6) @(posedge sys_clk);
    chk_io({28'h0, io_oe_n}, {28'h0, ~(dir_out | straps)});
    rd();
    drain();
    for (i = 0; i < 4; i++)
    begin
      send({3'h7, OP_SERIAL, 18'h00000, i[1:0]});
      expq.push_back({1'b1, 8'he0, 8'h00, SER[i*8 +: 8]});
    end
    drain();
    $display("test read and serial done");
    st_mode <= TAG_INT_OUT;
    send(25'h1d00000);
    expq.push_back(25'h1001000);
    i = 0;
    while (!st_out && i < 100)
    begin
      @(posedge sys_clk);
      i++;
    end
    n = 0;
    while (st_out && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_io(n, START_PULSE_CYC);
    chk_io({31'h0, st_oe_n}, 32'h0);
    drain();
    st_mode <= TAG_INT;
    repeat (3) @(posedge sys_clk);
    st_ext <= 1'b1;
    repeat (6) @(posedge sys_clk);
    st_ext <= 1'b0;
    send(25'h1d00000);
    expq.push_back(25'h1001000);
    drain();
    chk_io({31'h0, st_oe_n}, 32'h1);
    st_mode <= TAG_EXT;
    repeat (4) @(posedge sys_clk);
    rd();
    @(posedge sys_clk);
    st_ext <= 1'b1;
    expq.push_back(25'h1001000);
    drain();
    st_ext <= 1'b0;
    sc_mode <= TAG_EXT;
    repeat (4) @(posedge sys_clk);
    st_ext <= 1'b1;
    sc_ext <= 1'b1;
    expq.push_back(25'h1003000);
    drain();
    st_ext <= 1'b0;
    sc_ext <= 1'b0;
    repeat (4) @(posedge sys_clk);
    sc_ext <= 1'b1;
    expq.push_back(25'h1002000);
    drain();
    $display("test start and external tags done");
    st_mode <= stl_tag_mode_t'(2'h3);
    sc_mode <= TAG_INT_OUT;
    i = 0;
    while (!sc_out && i < 1200)
    begin
      @(posedge sys_clk);
      i++;
    end
    n = 0;
    while (sc_out && n < 1200)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_io(n, SHIGH);
    chk_io({31'h0, sc_oe_n}, 32'h0);
    while (!sc_out && n < 2400)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_io(n, SPER);
    expq.push_back(25'h1002000);
    expq.push_back(25'h1002000);
    drain();
    sc_mode <= stl_tag_mode_t'(2'h3);
    $display("test second tag done");
    stall <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 10; i++)
      rd();
    repeat (100) @(posedge sys_clk);
    chk_io({31'h0, i_ctl.rxq.size() > 0}, 32'h1);
    stall <= 1'b0;
    drain();
    $display("test fifo fill done");
    finish_test();
  end
endmodule
`default_nettype wire
